// ==== scpm_defines.vh ====
// Constants for the system clock and power mode controller.
`ifndef SCPM_DEFINES_VH
`define SCPM_DEFINES_VH
// Register addresses on the special-function register bus.
`define SCPM_ADDR_POWER     8'h87
`define SCPM_ADDR_TUNING    8'h94
`define SCPM_ADDR_P1WAKE    8'h96
`define SCPM_ADDR_CLKOUT    8'hA6
`define SCPM_ADDR_IRQEN     8'hA8
`define SCPM_ADDR_CLKSEL    8'hD8
`define SCPM_ADDR_TRIM      8'hF7
// Reset values.
`define SCPM_RST_POWER      8'h00
`define SCPM_RST_TUNING     8'hC1
`define SCPM_RST_P1WAKE     8'h00
`define SCPM_RST_CLKOUT     8'h00
`define SCPM_RST_IRQEN      8'h00
`define SCPM_RST_CLKSEL     8'h05
`define SCPM_RST_TRIM       5'h00
// Field positions in the clock select register.
`define SCPM_FAST_KIND_BIT  7
`define SCPM_FAST_OSC_BIT   6
`define SCPM_FAST_SEL_BIT   5
`define SCPM_SLOW_KIND_BIT  4
`define SCPM_STOP_FAST_BIT  3
// Field positions in the power, tuning and enable registers.
`define SCPM_STOP_REQ_BIT   1
`define SCPM_DOZE_REQ_BIT   0
`define SCPM_PERIPH_STOP_BIT 5
`define SCPM_GLOBAL_EN_BIT  7
`define SCPM_EXT0_EN_BIT    0
`define SCPM_EXT1_EN_BIT    2
// Bits of the power register that read back as stored.
`define SCPM_POWER_RW_MASK  8'h8C
// Bit 6 of the interrupt enable register is unimplemented.
`define SCPM_IRQEN_RW_MASK  8'hBF
// Oscillator indices in the source vectors.
`define SCPM_OSC_FRC        0
`define SCPM_OSC_FXT        1
`define SCPM_OSC_RFC        2
`define SCPM_OSC_SXT        3
`define SCPM_OSC_SRC        4
`endif

// ==== scpm_ctrl.v ====
// System clock selection, prescaler, clock output pin and Idle/Stop power mode control.
`timescale 1ns/10ps
`include "scpm_defines.vh"
module scpm_ctrl #(
	parameter P1_PINS = 8
) (
	input  wire               core_clk,
	input  wire               rst_n,
	input  wire               por_n,
	input  wire [7:0]         sfr_addr,
	input  wire [7:0]         sfr_wdata,
	input  wire               sfr_wr_en,
	input  wire               sfr_rd_en,
	output reg  [7:0]         sfr_rdata,
	input  wire [4:0]         flash_trim,
	input  wire [4:0]         osc_in,
	input  wire [2:0]         ext_irq_pin,
	input  wire [P1_PINS-1:0] port1_pin,
	input  wire               ext2_wake_enable,
	input  wire [5:0]         irq_req,
	input  wire               other_irq_wake,
	output reg  [4:0]         osc_enable,
	output reg  [4:0]         rc_trim_out,
	output reg                core_clock_tick,
	output reg                cpu_clk_en,
	output reg                periph_clk_en,
	output reg                uart_timer_clk_en,
	output reg                clock_out_pin,
	output reg                fast_mode,
	output reg                idle_active,
	output reg                stop_active
);

	localparam NUM_IN = 5 + 3 + P1_PINS;

	// ************************************************************
	// Functions
	// ************************************************************

	// Divider code to division ratio minus one.
	function [4:0] div_last;
		input [2:0] code;
			case (code)
				3'h0:    div_last = 5'h1F;
				3'h1:    div_last = 5'h0F;
				3'h2:    div_last = 5'h07;
				3'h3:    div_last = 5'h03;
				3'h4:    div_last = 5'h01;
				default: div_last = 5'h00;
			endcase
	endfunction

	// Clock out period in half system clock units, minus one.
	function [2:0] shape_last;
		input [2:0] code;
			case (code)
				3'h0:    shape_last = 3'h3;
				3'h1:    shape_last = 3'h5;
				3'h2:    shape_last = 3'h7;
				3'h3:    shape_last = 3'h3;
				3'h4:    shape_last = 3'h1;
				3'h5:    shape_last = 3'h5;
				3'h6:    shape_last = 3'h7;
				default: shape_last = 3'h3;
			endcase
	endfunction

	// Clock out high time in half system clock units.
	function [2:0] shape_high;
		input [2:0] code;
			case (code)
				3'h0:    shape_high = 3'h2;
				3'h1:    shape_high = 3'h2;
				3'h2:    shape_high = 3'h2;
				3'h3:    shape_high = 3'h1;
				3'h4:    shape_high = 3'h1;
				3'h5:    shape_high = 3'h4;
				3'h6:    shape_high = 3'h6;
				default: shape_high = 3'h3;
			endcase
	endfunction

	// ************************************************************
	// Input synchronisers
	// ************************************************************

	wire [NUM_IN-1:0] async_in;
	reg  [NUM_IN-1:0] sync1_reg;
	reg  [NUM_IN-1:0] sync2_reg;
	reg  [NUM_IN-1:0] sync3_reg;
	reg  [NUM_IN-1:0] level_reg;
	wire [NUM_IN-1:0] agree;
	wire [NUM_IN-1:0] rise;
	wire [NUM_IN-1:0] change;

	assign async_in = {port1_pin, ext_irq_pin, osc_in};

	// Three flops per input; a new level counts once stages two and three agree.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= {NUM_IN{1'b1}};
			sync2_reg <= {NUM_IN{1'b1}};
			sync3_reg <= {NUM_IN{1'b1}};
			level_reg <= {NUM_IN{1'b1}};
		end else begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= (sync3_reg & agree) | (level_reg & ~agree);
		end
	end

	// Per-input agreement and edge decode.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi = gi + 1) begin : g_sync
			assign agree[gi]  = (sync2_reg[gi] == sync3_reg[gi]);
			assign rise[gi]   = agree[gi] & sync3_reg[gi] & ~level_reg[gi];
			assign change[gi] = agree[gi] & (sync3_reg[gi] != level_reg[gi]);
		end
	endgenerate

	wire [4:0]         osc_rise  = rise[4:0];
	wire [2:0]         ext_level = level_reg[7:5];
	wire [P1_PINS-1:0] p1_change = change[NUM_IN-1:8];

	// ************************************************************
	// Registers
	// ************************************************************

	reg [7:0] power_mode_ctrl_reg;
	reg [7:0] peripheral_tuning_reg;
	reg [7:0] port1_wake_mask_reg;
	reg [7:0] timer_clock_out_ctrl_reg;
	reg [7:0] irq_enable_main_reg;
	reg [7:0] core_clock_select_ctrl_reg;
	reg [4:0] rc_trim_reg;
	reg       trim_loaded_reg;
	reg       idle_reg;
	reg       stop_reg;
	reg [7:0] clksel_next;

	wire wr_power  = sfr_wr_en & (sfr_addr == `SCPM_ADDR_POWER);
	wire wr_clksel = sfr_wr_en & (sfr_addr == `SCPM_ADDR_CLKSEL);

	wire fast_sel  = core_clock_select_ctrl_reg[`SCPM_FAST_SEL_BIT];
	wire fast_kind = core_clock_select_ctrl_reg[`SCPM_FAST_KIND_BIT];
	wire fast_osc  = core_clock_select_ctrl_reg[`SCPM_FAST_OSC_BIT];
	wire slow_kind = core_clock_select_ctrl_reg[`SCPM_SLOW_KIND_BIT];
	wire stop_fast = core_clock_select_ctrl_reg[`SCPM_STOP_FAST_BIT];

	// Wake sources for Stop: enabled low external pins and enabled Port1 changes.
	wire [2:0] ext_en = {ext2_wake_enable,
		irq_enable_main_reg[`SCPM_EXT1_EN_BIT], irq_enable_main_reg[`SCPM_EXT0_EN_BIT]};
	wire ext_wake  = |(~ext_level & ext_en);
	wire pin_wake  = ext_wake | (|(p1_change & port1_wake_mask_reg[P1_PINS-1:0]));
	wire idle_wake = (irq_enable_main_reg[`SCPM_GLOBAL_EN_BIT] &
		(|(irq_req & irq_enable_main_reg[5:0]))) | other_irq_wake | pin_wake;

	// Each field of the clock select register only takes a write when legal.
	always @* begin
		clksel_next = core_clock_select_ctrl_reg;
		clksel_next[2:0] = sfr_wdata[2:0];
		if (!fast_sel) begin
			clksel_next[`SCPM_FAST_KIND_BIT] = sfr_wdata[`SCPM_FAST_KIND_BIT];
			clksel_next[`SCPM_FAST_OSC_BIT]  = sfr_wdata[`SCPM_FAST_OSC_BIT];
		end
		if (fast_sel)
			clksel_next[`SCPM_SLOW_KIND_BIT] = sfr_wdata[`SCPM_SLOW_KIND_BIT];
		if (!fast_sel || fast_kind)
			clksel_next[`SCPM_STOP_FAST_BIT] = sfr_wdata[`SCPM_STOP_FAST_BIT];
		if (!stop_fast || fast_kind)
			clksel_next[`SCPM_FAST_SEL_BIT] = sfr_wdata[`SCPM_FAST_SEL_BIT];
	end

	// Register file writes and power mode state.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			power_mode_ctrl_reg      <= `SCPM_RST_POWER;
			peripheral_tuning_reg    <= `SCPM_RST_TUNING;
			port1_wake_mask_reg      <= `SCPM_RST_P1WAKE;
			timer_clock_out_ctrl_reg <= `SCPM_RST_CLKOUT;
			irq_enable_main_reg      <= `SCPM_RST_IRQEN;
			core_clock_select_ctrl_reg   <= `SCPM_RST_CLKSEL;
			idle_reg                 <= 1'b0;
			stop_reg                 <= 1'b0;
		end else begin
			if (sfr_wr_en && sfr_addr == `SCPM_ADDR_TUNING)
				peripheral_tuning_reg <= sfr_wdata;
			if (sfr_wr_en && sfr_addr == `SCPM_ADDR_P1WAKE)
				port1_wake_mask_reg <= sfr_wdata;
			if (sfr_wr_en && sfr_addr == `SCPM_ADDR_CLKOUT)
				timer_clock_out_ctrl_reg <= sfr_wdata;
			if (sfr_wr_en && sfr_addr == `SCPM_ADDR_IRQEN)
				irq_enable_main_reg <= sfr_wdata & `SCPM_IRQEN_RW_MASK;
			if (wr_clksel)
				core_clock_select_ctrl_reg <= clksel_next;
			if (wr_power)
				power_mode_ctrl_reg <= sfr_wdata & `SCPM_POWER_RW_MASK;
			// A write that sets Idle, or sets Stop with no enabled external pin low, wins over a wake in the same cycle.
			if (wr_power && sfr_wdata[`SCPM_DOZE_REQ_BIT])
				idle_reg <= 1'b1;
			else if (idle_wake)
				idle_reg <= 1'b0;
			if (wr_power && sfr_wdata[`SCPM_STOP_REQ_BIT] && !ext_wake)
				stop_reg <= 1'b1;
			else if (pin_wake)
				stop_reg <= 1'b0;
		end
	end

	// Trim loads from flash once after power-on; other resets leave it alone.
	always @(posedge core_clk or negedge por_n) begin
		if (!por_n) begin
			rc_trim_reg     <= `SCPM_RST_TRIM;
			trim_loaded_reg <= 1'b0;
		end else if (!trim_loaded_reg) begin
			rc_trim_reg     <= flash_trim;
			trim_loaded_reg <= 1'b1;
		end else if (sfr_wr_en && sfr_addr == `SCPM_ADDR_TRIM) begin
			rc_trim_reg     <= sfr_wdata[4:0];
		end
	end

	// Registered read data; unmapped addresses read zero.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd_en) begin
			case (sfr_addr)
				`SCPM_ADDR_POWER:  sfr_rdata <= power_mode_ctrl_reg | {6'h00, stop_reg, idle_reg};
				`SCPM_ADDR_TUNING: sfr_rdata <= peripheral_tuning_reg;
				`SCPM_ADDR_P1WAKE: sfr_rdata <= port1_wake_mask_reg;
				`SCPM_ADDR_CLKOUT: sfr_rdata <= timer_clock_out_ctrl_reg;
				`SCPM_ADDR_IRQEN:  sfr_rdata <= irq_enable_main_reg;
				`SCPM_ADDR_CLKSEL: sfr_rdata <= core_clock_select_ctrl_reg;
				`SCPM_ADDR_TRIM:   sfr_rdata <= {3'h0, rc_trim_reg};
				default:           sfr_rdata <= 8'h00;
			endcase
		end
	end

	// ************************************************************
	// Source selection and prescaler
	// ************************************************************

	reg  [4:0] div_cnt_reg;
	reg        src_edge;
	reg  [4:0] osc_en_next;
	wire [4:0] div_end  = div_last(core_clock_select_ctrl_reg[2:0]);
	wire       tick     = src_edge & (div_cnt_reg == div_end);
	wire       half_mid = src_edge & (div_cnt_reg == {1'b0, div_end[4:1]}) & (div_end != 5'h00);
	wire       half     = tick | half_mid;

	// Pick the edge of the oscillator that feeds the system clock.
	always @* begin
		if (fast_sel) begin
			if (fast_kind)
				src_edge = osc_rise[`SCPM_OSC_RFC];
			else if (fast_osc)
				src_edge = osc_rise[`SCPM_OSC_FXT];
			else
				src_edge = osc_rise[`SCPM_OSC_FRC];
		end else begin
			src_edge = slow_kind ? osc_rise[`SCPM_OSC_SXT] : osc_rise[`SCPM_OSC_SRC];
		end
		if (stop_reg)
			src_edge = 1'b0;
	end

	// Oscillator enables; all stop in Stop mode.
	always @* begin
		osc_en_next = 5'h00;
		osc_en_next[`SCPM_OSC_FRC] = ~fast_kind & ~fast_osc & ~stop_fast;
		osc_en_next[`SCPM_OSC_FXT] = ~fast_kind & fast_osc & ~stop_fast;
		osc_en_next[`SCPM_OSC_RFC] = fast_kind;
		osc_en_next[`SCPM_OSC_SXT] = slow_kind;
		osc_en_next[`SCPM_OSC_SRC] = ~slow_kind;
		if (stop_reg)
			osc_en_next = 5'h00;
	end

	// Count source edges; a wrap gives one system clock tick.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			div_cnt_reg <= 5'h00;
		else if (src_edge)
			div_cnt_reg <= (div_cnt_reg >= div_end) ? 5'h00 : div_cnt_reg + 5'h01;
	end

	// ************************************************************
	// Clock output shaping
	// ************************************************************

	reg  [2:0] shape_cnt_reg;
	wire [2:0] shape_code = timer_clock_out_ctrl_reg[2:0];
	wire [2:0] shape_end  = shape_last(shape_code);

	// Phase counter in half system clock steps, or whole steps for divider codes 5 to 7.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			shape_cnt_reg <= 3'h0;
		else if (half)
			shape_cnt_reg <= (shape_cnt_reg >= shape_end) ? 3'h0 : shape_cnt_reg + 3'h1;
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************

	// Clock enables: CPU stops in Idle, UART/timer optionally, all in Stop.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_clock_tick   <= 1'b0;
			cpu_clk_en        <= 1'b0;
			periph_clk_en     <= 1'b0;
			uart_timer_clk_en <= 1'b0;
			clock_out_pin     <= 1'b0;
			osc_enable        <= 5'h00;
			rc_trim_out       <= `SCPM_RST_TRIM;
			fast_mode         <= 1'b0;
			idle_active       <= 1'b0;
			stop_active       <= 1'b0;
		end else begin
			core_clock_tick   <= tick;
			cpu_clk_en        <= tick & ~idle_reg;
			periph_clk_en     <= tick;
			uart_timer_clk_en <= tick & ~(idle_reg &
				peripheral_tuning_reg[`SCPM_PERIPH_STOP_BIT]);
			clock_out_pin     <= (shape_cnt_reg < shape_high(shape_code));
			osc_enable        <= osc_en_next;
			rc_trim_out       <= rc_trim_reg;
			fast_mode         <= fast_sel;
			idle_active       <= idle_reg;
			stop_active       <= stop_reg;
		end
	end

endmodule // scpm_ctrl

// ==== scpm_ctrl_monitor.sv ====
// Assertion checker for the clock and power mode controller ports.
`timescale 1ns/10ps
`include "scpm_defines.vh"
// ****
// Checker
// ****
module scpm_ctrl_monitor #(
	parameter P1_PINS = 8
) (
	input wire logic               core_clk,
	input wire logic               rst_n,
	input wire logic [7:0]         sfr_addr,
	input wire logic [7:0]         sfr_wdata,
	input wire logic               sfr_wr_en,
	input wire logic [2:0]         ext_irq_pin,
	input wire logic [P1_PINS-1:0] port1_pin,
	input wire logic               ext2_wake_enable,
	input wire logic [4:0]         osc_enable,
	input wire logic               core_clock_tick,
	input wire logic               cpu_clk_en,
	input wire logic               periph_clk_en,
	input wire logic               uart_timer_clk_en,
	input wire logic               idle_active,
	input wire logic               stop_active
);
	logic [7:0]         ie_sh;
	logic               pstop_sh;
	logic [3:0]         quiet;
	logic [P1_PINS+2:0] pins_q;
	wire  [2:0]         ext_en = {ext2_wake_enable, ie_sh[2], ie_sh[0]};
	// Shadows the enable bits and counts cycles since any wake pin moved.
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ie_sh <= 8'h00;
			pstop_sh <= 1'b0;
			quiet <= 4'h0;
			pins_q <= '1;
		end else begin
			if (sfr_wr_en && sfr_addr == `SCPM_ADDR_IRQEN)
				ie_sh <= sfr_wdata;
			if (sfr_wr_en && sfr_addr == `SCPM_ADDR_TUNING)
				pstop_sh <= sfr_wdata[5];
			pins_q <= {ext_irq_pin, port1_pin};
			if (pins_q != {ext_irq_pin, port1_pin})
				quiet <= 4'h0;
			else if (quiet != 4'hF)
				quiet <= quiet + 4'h1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence stopped_s; stop_active [*3]; endsequence
	sequence pd_wr_s; sfr_wr_en && sfr_addr == `SCPM_ADDR_POWER && sfr_wdata[1]; endsequence
	stop_clocks_a: assert property (stopped_s |-> osc_enable == 5'h00 && !periph_clk_en)
		else $error("clocks run in stop");
	idle_cpu_a: assert property (idle_active && $past(idle_active) |-> !cpu_clk_en)
		else $error("cpu clock runs in idle");
	cpu_run_a: assert property (!idle_active && !stop_active && $past(!idle_active && !stop_active)
		|-> cpu_clk_en == core_clock_tick) else $error("cpu clock lost");
	periph_run_a: assert property (!stop_active && $past(!stop_active)
		|-> periph_clk_en == core_clock_tick) else $error("peripheral clock lost");
	uart_gate_a: assert property (idle_active && $past(idle_active) && pstop_sh
		|-> !uart_timer_clk_en) else $error("uart clock runs in idle");
	stop_refuse_a: assert property (pd_wr_s ##0 !stop_active
		&& |(ext_en & ~ext_irq_pin & ~$past(ext_irq_pin, 4)) |=> !stop_active [*3])
		else $error("stop entered with pin low");
	stop_wake_a: assert property (stop_active && |(ext_en & ~ext_irq_pin)
		|-> ##[1:8] !stop_active) else $error("pin did not wake");
	stop_hold_a: assert property (stop_active && quiet > 4'h5 && &ext_irq_pin
		|=> stop_active) else $error("stop left without pin");
endmodule // scpm_ctrl_monitor

// ==== scpm_osc_model.sv ====
// Oscillator sources that toggle only while enabled.
`timescale 1ns/10ps
// ****
// Oscillators
// ****
module scpm_osc_model (
	input  wire logic [4:0] osc_enable,
	output wire logic [4:0] osc_in
);
	localparam int HALF [5] = '{16, 18, 22, 37, 27};
	// Each source has its own rate; a stopped one rests low.
	for (genvar g = 0; g < 5; g++) begin : g_osc
		logic lvl = 1'b0;
		initial #0.3 forever begin
			#(HALF[g]);
			lvl = osc_enable[g] ? ~lvl : 1'b0;
		end
		assign osc_in[g] = lvl;
	end
endmodule // scpm_osc_model

// ==== scpm_tb.sv ====
// Self-checking bench for the clock and power mode controller.
`timescale 1ns/10ps
`include "scpm_defines.vh"
// ****
// Bench
// ****
module tb;
	logic       core_clk = 0, rst_n = 0, por_n = 0, sfr_wr_en = 0, sfr_rd_en = 0;
	logic       ext2_wake_enable = 0, other_irq_wake = 0, core_clock_tick, cpu_clk_en;
	logic       periph_clk_en, uart_timer_clk_en, clock_out_pin, fast_mode;
	logic       idle_active, stop_active;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, port1_pin = 8'hFF, d, v, tl;
	logic [4:0] flash_trim = 0, osc_in, osc_enable, rc_trim_out;
	logic [2:0] ext_irq_pin = 3'h7;
	logic [5:0] irq_req = 0;
	int         num_errors = 0, cmp_count = 0, seed = 38524, n, k, e, per, hi;
	logic [15:0] rv [8] = '{16'h8700, 16'h94C1, 16'h9600, 16'hA600, 16'hA800, 16'hD805,
		16'h9000, 16'hF700};
	logic [15:0] rw [5] = '{16'h94FF, 16'h96FF, 16'hA6FF, 16'hA8BF, 16'h9000};
	logic [15:0] cs [14] = '{16'h2525, 16'hE525, 16'h3535, 16'h3D35, 16'h1515, 16'h0515,
		16'h1D1D, 16'h3D1D, 16'h1414, 16'h5454, 16'hD4D4, 16'hDCDC, 16'hFCFC, 16'h7CFC};
	logic [7:0]  co [8] = '{8'h42, 8'h62, 8'h82, 8'h41, 8'h21, 8'h64, 8'h86, 8'h43};
	logic [7:0]  tv [3] = '{8'h00, 8'h0F, 8'h10};
	scpm_ctrl #(.P1_PINS(8)) scpm_ctrl_i (.*);
	scpm_osc_model scpm_osc_model_i (.*);
	// Free-running core clock.
	always #5 core_clk = ~core_clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		cyc(1);
		{sfr_addr, sfr_wdata, sfr_wr_en} = {a, w, 1'b1};
		cyc(1);
		sfr_wr_en = 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		cyc(1);
		{sfr_addr, sfr_rd_en} = {a, 1'b1};
		cyc(1);
		sfr_rd_en = 0;
		r = sfr_rdata;
	endtask
	task automatic wait_for(input int w, input logic x);
		cmp_count++;
		for (int i = 0; i < 400; i++) begin
			if ((w == 0 ? stop_active : idle_active) === x)
				return;
			cyc(1);
		end
		num_errors++;
		$display("mismatch at %0t: wait ran out", $time);
		close_out();
	endtask
	// Counts source edges over one system clock period.
	task automatic meas(input int idx, output int c);
		logic p;
		int t;
		c = 0;
		t = 0;
		p = osc_in[idx];
		for (int i = 0; i < 2000 && t < 3; i++) begin
			@(negedge core_clk);
			if (t == 2 && osc_in[idx] && !p)
				c++;
			p = osc_in[idx];
			t += core_clock_tick;
		end
	endtask
	// Counts ticks over two output periods and while the output is high.
	task automatic co_meas(output int pc, output int hc);
		logic p;
		int r;
		{pc, hc, r} = 0;
		p = clock_out_pin;
		for (int i = 0; i < 3000 && r < 4; i++) begin
			@(negedge core_clk);
			r += clock_out_pin && !p;
			p = clock_out_pin;
			if (r >= 2 && r < 4 && core_clock_tick) begin
				pc++;
				hc += clock_out_pin;
			end
		end
	endtask
	function automatic int divx(input int c);
		return c < 5 ? 32 >> c : 1;
	endfunction
	// Main sequence.
	initial begin
		flash_trim = 5'($random(seed));
		cyc(4);
		{rst_n, por_n} = 2'b11;
		cyc(2);
		for (n = 0; n < 8; n++) begin
			rd(rv[n][15:8], d);
			check(d, rv[n][7:0] | (n == 7 ? {3'h0, flash_trim} : 8'h00));
		end
		check({fast_mode, osc_enable, rc_trim_out}, {1'b0, 5'h11, flash_trim});
		for (n = 0; n < 5; n++) begin
			v = $random(seed);
			wr(rw[n][15:8], v);
			rd(rw[n][15:8], d);
			check(d, v & rw[n][7:0]);
		end
		for (n = 0; n < 4; n++) begin
			tl = n < 3 ? tv[n] : 8'($random(seed));
			wr(`SCPM_ADDR_TRIM, tl);
			tl = tl & 8'h1F;
			rd(`SCPM_ADDR_TRIM, d);
			check({d, 3'h0, rc_trim_out}, {tl, tl});
		end
		for (n = 0; n < 8; n++) begin
			wr(`SCPM_ADDR_CLKSEL, 8'(n));
			meas(4, e);
			check(e, divx(n));
		end
		for (n = 0; n < 14; n++) begin
			wr(`SCPM_ADDR_CLKSEL, cs[n][15:8]);
			rd(`SCPM_ADDR_CLKSEL, d);
			cyc(2);
			check({d, fast_mode}, {cs[n][7:0], cs[n][5]});
			if (n == 6)
				check(osc_enable[1:0], 2'h0);
		end
		meas(2, e);
		check(e, 2);
		wr(`SCPM_ADDR_CLKSEL, 8'hDC);
		meas(3, e);
		check(e, 2);
		for (n = 0; n < 8; n++) begin
			wr(`SCPM_ADDR_CLKOUT, 8'(n));
			co_meas(per, hi);
			check(per, co[n][7:4]);
			if (!co[n][0])
				check(hi, co[n][3:0]);
		end
		wr(`SCPM_ADDR_TUNING, 8'hE1);
		wr(`SCPM_ADDR_IRQEN, 8'h82);
		irq_req = 6'h01;
		wr(`SCPM_ADDR_POWER, 8'h01);
		wait_for(1, 1);
		cyc(40);
		check(idle_active, 1);
		irq_req = 6'h02;
		wait_for(1, 0);
		irq_req = 0;
		wr(`SCPM_ADDR_POWER, 8'h01);
		wait_for(1, 1);
		other_irq_wake = 1;
		wait_for(1, 0);
		other_irq_wake = 0;
		for (n = 0; n < 3; n++) begin
			wr(`SCPM_ADDR_IRQEN, n == 0 ? 8'h01 : n == 1 ? 8'h04 : 8'h00);
			ext2_wake_enable = n == 2;
			ext_irq_pin[n] = 0;
			cyc(6);
			wr(`SCPM_ADDR_POWER, 8'h02);
			cyc(4);
			check(stop_active, 0);
			ext_irq_pin[n] = 1;
			cyc(6);
			wr(`SCPM_ADDR_POWER, 8'h02);
			wait_for(0, 1);
			{irq_req, other_irq_wake} = 7'h7F;
			cyc(20);
			check({stop_active, osc_enable}, 6'h20);
			{irq_req, other_irq_wake} = 0;
			ext_irq_pin[n] = 0;
			wait_for(0, 0);
			ext_irq_pin[n] = 1;
			cyc(6);
		end
		k = {$random(seed)} % 8;
		{ext2_wake_enable, irq_req} = 0;
		wr(`SCPM_ADDR_IRQEN, 8'h00);
		wr(`SCPM_ADDR_P1WAKE, 8'h01 << k);
		wr(`SCPM_ADDR_POWER, 8'h02);
		wait_for(0, 1);
		port1_pin[(k + 1) % 8] = 0;
		cyc(12);
		check(stop_active, 1);
		port1_pin[k] = 0;
		wait_for(0, 0);
		rst_n = 0;
		cyc(3);
		rst_n = 1;
		cyc(2);
		rd(`SCPM_ADDR_CLKSEL, d);
		check({d, osc_enable, rc_trim_out}, {8'h05, 5'h11, tl[4:0]});
		close_out();
	end
endmodule // tb
bind scpm_ctrl scpm_ctrl_monitor #(.P1_PINS(P1_PINS)) scpm_ctrl_monitor_i (.*);
